// *** bench/cmb_decode_core_props.sv ***
// Port checker for the move, branch and bit instruction decoder
`timescale 1ns/10ps
module cmb_decode_core_props import cmb_pkg::*; (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] xRdData,
  input wire logic memWrSel,
  input wire logic [15:0] codeAddr,
  input wire cmb_xreq_t xReq,
  input wire logic [7:0] accOut,
  input wire logic carryOut,
  input wire logic [15:0] dataPtrOut,
  input wire logic [15:0] pcOut,
  input wire logic [7:0] spOut,
  input wire logic insnDone,
  input wire logic badOpcode
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // ==========================================================
  // Completion and program flow
  bad_with_done_a: assert property (badOpcode |-> insnDone)
    else $error("unsupported opcode flagged without completion");
  bad_step_a: assert property (badOpcode |-> pcOut == $past(pcOut) + 16'h0001 && $stable(accOut))
    else $error("unsupported opcode did not step one byte");
  // State may move only at instruction ends; reset exit is excluded
  state_at_end_a: assert property (!$stable({accOut, carryOut, dataPtrOut, pcOut, spOut}) && !$past(srst) |-> insnDone)
    else $error("state changed outside an instruction end");
  next_fetch_a: assert property (insnDone |-> codeAddr == pcOut)
    else $error("fetch address differs from program counter");
  stack_step_a: assert property ($changed(spOut) && !$past(srst) |-> spOut == $past(spOut) + 8'h01 || spOut == $past(spOut) - 8'h01)
    else $error("stack pointer moved by more than one");
  // ==========================================================
  // External data strobes
  acc_from_read_a: assert property (xReq.rd |-> ##2 (insnDone && accOut == $past(xRdData)))
    else $error("external read data not in accumulator at end");
  read_single_a: assert property (xReq.rd |=> (!xReq.rd && !xReq.wr) [*2])
    else $error("extra strobe after external read");
  write_done_a: assert property (xReq.wr |=> insnDone && !xReq.wr)
    else $error("external write was not the last cycle");
  write_data_a: assert property (xReq.wr |-> xReq.wdata == accOut)
    else $error("external write data differs from accumulator");
  space_flag_a: assert property ((xReq.rd || xReq.wr) |-> xReq.codeSpace == $past(memWrSel))
    else $error("access space flag differs from write select");
  addr_form_a: assert property ((xReq.rd || xReq.wr) |-> xReq.addr == dataPtrOut || xReq.addr[15:8] == 8'h00)
    else $error("external address neither pointer nor index form");
  cover property (xReq.rd);
  cover property (xReq.wr);
endmodule

bind cmb_decode_core cmb_decode_core_props u_props (
  .core_clk(core_clk),
  .srst(srst),
  .xRdData(xRdData),
  .memWrSel(memWrSel),
  .codeAddr(codeAddr),
  .xReq(xReq),
  .accOut(accOut),
  .carryOut(carryOut),
  .dataPtrOut(dataPtrOut),
  .pcOut(pcOut),
  .spOut(spOut),
  .insnDone(insnDone),
  .badOpcode(badOpcode)
);

// *** bench/cmb_mem_model.sv ***
// Program memory and external data memory facing the decoder
`timescale 1ns/10ps
module cmb_mem_model import cmb_pkg::*; (
  input wire logic core_clk,
  input wire logic [15:0] codeAddr,
  input wire cmb_xreq_t xReq,
  output cmb_code_t codeData,
  output logic [7:0] xRdData
);
  logic [7:0] rom [0:65535];
  logic [7:0] xram [0:65535];
  // ==========================================================
  // Program memory: fill pattern so unwritten bytes are known
  initial begin
    for (int i = 0; i < 65536; i++) begin
      rom[i] = 8'(i) ^ 8'(i >> 8) ^ 8'hC3;
    end
  end
  assign codeData = {rom[codeAddr + 16'h0002], rom[codeAddr + 16'h0001], rom[codeAddr]};
  // ==========================================================
  // External data: no wait states, answer valid one cycle after the strobe
  always @(posedge core_clk) begin
    if (xReq.rd) begin
      xRdData <= xram[xReq.addr];
    end else begin
      // Line is not held between reads, so stale data never passes
      xRdData <= ~xRdData;
    end
    if (xReq.wr) begin
      xram[xReq.addr] <= xReq.wdata;
    end
  end
endmodule

// *** bench/testbench.sv ***
// Self-checking bench running one program through the decoder
`timescale 1ns/10ps
module testbench import cmb_pkg::*; ;
  typedef struct packed {
    logic [2:0] cyc;
    logic [15:0] pc;
    logic [7:0] acc;
    logic c;
    logic [15:0] dp;
    logic [7:0] sp;
    logic bad;
  } cmb_note_t;
  logic core_clk, srst, memWrSel, carryOut, insnDone, badOpcode;
  logic [15:0] codeAddr, dataPtrOut, pcOut, pc, eDp, cnt;
  logic [7:0] xRdData, accOut, spOut, eA, eSp;
  logic eC, eBad;
  logic [7:0] r [1:7];
  cmb_code_t codeData;
  cmb_xreq_t xReq;
  cmb_note_t notes[$];
  cmb_note_t note;
  int seed = 86;
  int rv, wv, err_total, tests_run;

  cmb_decode_core dut (.core_clk(core_clk), .srst(srst), .codeData(codeData), .xRdData(xRdData),
    .memWrSel(memWrSel), .codeAddr(codeAddr), .xReq(xReq), .accOut(accOut), .carryOut(carryOut),
    .dataPtrOut(dataPtrOut), .pcOut(pcOut), .spOut(spOut), .insnDone(insnDone), .badOpcode(badOpcode));
  cmb_mem_model mem (.core_clk(core_clk), .codeAddr(codeAddr), .xReq(xReq), .codeData(codeData),
    .xRdData(xRdData));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // Random write select; each strobe must echo it in the space flag
  always @(posedge core_clk) begin
    #1;
    wv = $random(seed);
    memWrSel = wv[0];
  end

  // ==========================================================
  // Checking helpers
  task automatic chk(input string what, input logic [15:0] expv, input logic [15:0] got);
    tests_run++;
    if (got !== expv) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, expv, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("Checks made %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Place one instruction at pc and note its timing and resulting state
  task automatic op(input logic [1:0] len, input logic [2:0] cyc, input int off, input logic [7:0] b0,
                    input logic [7:0] b1 = 8'h00, input logic [7:0] b2 = 8'h00);
    mem.rom[pc] = b0;
    mem.rom[pc + 16'h0001] = b1;
    mem.rom[pc + 16'h0002] = b2;
    pc = pc + {14'h0000, len} + 16'(off);
    notes.push_back('{cyc, pc, eA, eC, eDp, eSp, eBad});
  endtask

  // Cycle count runs from one completion to the next
  // Sampled mid-cycle, well away from the edge that moves the outputs
  always @(negedge core_clk) begin
    if (srst) begin
      cnt = 16'h0000;
    end else if (insnDone === 1'b1) begin
      if (notes.size() > 0) begin
        note = notes.pop_front();
        chk("cycles", {13'h0000, note.cyc}, cnt);
        chk("pc", note.pc, pcOut);
        chk("acc", {8'h00, note.acc}, {8'h00, accOut});
        chk("carry", {15'h0000, note.c}, {15'h0000, carryOut});
        chk("data_pointer", note.dp, dataPtrOut);
        chk("sp", {8'h00, note.sp}, {8'h00, spOut});
        chk("bad", {15'h0000, note.bad}, {15'h0000, badOpcode});
      end
      cnt = 16'h0001;
    end else begin
      cnt = cnt + 16'h0001;
    end
  end

  // ==========================================================
  // Program build and run
  initial begin
    srst = 1'b1;
    pc = 16'h0000;
    eA = 8'h00;
    eC = 1'b0;
    eDp = 16'h0000;
    eSp = 8'h07;
    eBad = 1'b0;
    #1;
    for (int i = 1; i < 8; i++) begin
      rv = $random(seed);
      r[i] = rv[7:0];
    end
    op(2'h3, 3'h3, 0, 8'h75, 8'h30, r[1]);
    eA = r[1]; op(2'h2, 3'h3, 0, 8'hC5, 8'h30);
    eDp = {r[2], r[3]}; op(2'h3, 3'h3, 0, 8'h90, r[2], r[3]);
    op(2'h1, 3'h5, 0, 8'hF0);
    eBad = 1'b1; op(2'h1, 3'h1, 0, 8'hE4);
    eBad = 1'b0; eA = 8'h00; op(2'h2, 3'h3, 0, 8'hC5, 8'h30);
    eA = r[1]; op(2'h1, 3'h4, 0, 8'hE0);
    op(2'h3, 3'h3, 0, 8'h75, 8'h00, r[4]);
    op(2'h1, 3'h5, 0, 8'hF2);
    op(2'h3, 3'h3, 0, 8'h75, 8'h31, r[5]);
    eA = r[5]; op(2'h2, 3'h3, 0, 8'hC5, 8'h31);
    eA = r[1]; op(2'h1, 3'h4, 0, 8'hE2);
    op(2'h3, 3'h3, 0, 8'h75, 8'h00, 8'h40);
    op(2'h2, 3'h3, 0, 8'h76, r[6]);
    eA = r[6]; op(2'h1, 3'h3, 0, 8'hC6);
    op(2'h1, 3'h3, 0, 8'hF6);
    op(2'h3, 3'h3, 0, 8'h75, 8'h41, r[7]);
    eA = r[7]; op(2'h2, 3'h3, 0, 8'hC5, 8'h41);
    eA = r[6]; op(2'h1, 3'h3, 0, 8'hC6);
    op(2'h3, 3'h3, 0, 8'h75, 8'h42, r[2]);
    op(2'h2, 3'h5, 0, 8'hA6, 8'h42);
    eA = {r[6][7:4], r[2][3:0]}; op(2'h1, 3'h3, 0, 8'hD6);
    eA = {r[2][7:4], r[6][3:0]}; op(2'h1, 3'h3, 0, 8'hC6);
    eA = 8'h40; op(2'h1, 3'h2, 0, 8'hC8);
    eSp = 8'h08; op(2'h2, 3'h4, 0, 8'hC0, 8'h30);
    eSp = 8'h07; op(2'h2, 3'h3, 0, 8'hD0, 8'h32);
    eA = r[1]; op(2'h2, 3'h3, 0, 8'hC5, 8'h32);
    op(2'h3, 3'h3, 0, 8'h75, 8'h33, 8'h00);
    eA = 8'h00; op(2'h2, 3'h3, 0, 8'hC5, 8'h33);
    op(2'h2, 3'h3, 0, 8'h70, 8'h10);
    op(2'h2, 3'h3, 3, 8'h60, 8'h03);
    op(2'h2, 3'h3, 5, 8'h80, 8'h05);
    op(2'h2, 3'h3, -7, 8'h80, 8'hF9);
    op(2'h2, 3'h3, 5, 8'h60, 8'h05);
    op(2'h1, 3'h1, 0, 8'hC3);
    op(2'h2, 3'h3, 0, 8'h40, 8'h05);
    op(2'h2, 3'h3, 2, 8'h50, 8'h02);
    eC = 1'b1; op(2'h1, 3'h1, 0, 8'hD3);
    op(2'h2, 3'h3, 1, 8'h40, 8'h01);
    eC = 1'b0; op(2'h1, 3'h1, 0, 8'hB3);
    op(2'h3, 3'h3, 0, 8'h75, 8'h20, 8'h00);
    op(2'h2, 3'h3, 0, 8'hD2, 8'h00);
    op(2'h3, 3'h4, 4, 8'h20, 8'h00, 8'h04);
    op(2'h3, 3'h4, 2, 8'h10, 8'h00, 8'h02);
    op(2'h3, 3'h4, 0, 8'h10, 8'h00, 8'h02);
    op(2'h3, 3'h4, 1, 8'h30, 8'h00, 8'h01);
    op(2'h3, 3'h4, 0, 8'h20, 8'h00, 8'h7F);
    op(2'h2, 3'h3, 0, 8'hB2, 8'h00);
    eC = 1'b1; op(2'h2, 3'h2, 0, 8'hA2, 8'h00);
    op(2'h2, 3'h3, 0, 8'hC2, 8'h00);
    eC = 1'b0; op(2'h2, 3'h2, 0, 8'h82, 8'h00);
    op(2'h2, 3'h2, 0, 8'h72, 8'h00);
    eC = 1'b1; op(2'h2, 3'h2, 0, 8'hA0, 8'h00);
    op(2'h2, 3'h2, 0, 8'hB0, 8'h00);
    op(2'h2, 3'h3, 0, 8'h92, 8'h01);
    op(2'h3, 3'h4, 2, 8'h20, 8'h01, 8'h02);
    op(2'h3, 3'h4, 3, 8'hB4, 8'h05, 8'h03);
    eC = 1'b0; op(2'h3, 3'h4, 0, 8'hB4, 8'h00, 8'h03);
    op(2'h3, 3'h3, 0, 8'h75, 8'h34, 8'h80);
    eC = 1'b1; op(2'h3, 3'h4, 2, 8'hB5, 8'h34, 8'h02);
    op(2'h3, 3'h3, 0, 8'h75, 8'h01, 8'h02);
    eC = 1'b0; op(2'h3, 3'h4, 0, 8'hB9, 8'h02, 8'h05);
    op(2'h3, 3'h3, 0, 8'h75, 8'h00, 8'h40);
    op(2'h2, 3'h3, 0, 8'h76, 8'h10);
    op(2'h3, 3'h4, 4, 8'hB6, 8'h0F, 8'h04);
    op(2'h2, 3'h3, 2, 8'hD9, 8'h02);
    op(2'h2, 3'h3, 0, 8'hD9, 8'h02);
    op(2'h3, 3'h4, 1, 8'hD5, 8'h34, 8'h01);
    eDp = 16'h8000; op(2'h3, 3'h3, 0, 8'h90, 8'h80, 8'h00);
    eA = mem.rom[16'h8000 + {8'h00, eA}]; op(2'h1, 3'h3, 0, 8'h93);
    eA = mem.rom[pc + 16'h0001 + {8'h00, eA}]; op(2'h1, 3'h3, 0, 8'h83);
    eDp = 16'h0200; op(2'h3, 3'h3, 0, 8'h90, 8'h02, 8'h00);
    op(2'h1, 3'h2, 32'h200 + int'(eA) - int'(pc) - 1, 8'h73);
    op(2'h2, 3'h3, -2, 8'h80, 8'hFE);
    op(2'h2, 3'h3, -2, 8'h80, 8'hFE);
    repeat (10) @(posedge core_clk);
    #1 srst = 1'b0;
    for (int i = 0; i < 3000 && notes.size() > 0; i++) begin
      @(posedge core_clk);
    end
    if (notes.size() > 0) begin
      err_total++;
      $display("BAD completions expected %0d seen 0", notes.size());
    end
    $display("Program run finished");
    tally_and_finish();
  end
endmodule

// *** hdl/cmb_consts.svh ***
// Constants for the move, branch and bit instruction decoder
`ifndef CMB_CONSTS_SVH
`define CMB_CONSTS_SVH
// Opcodes; ranged forms are named by their lowest code
`define OP_MOV_DIR_IMM 8'h75
`define OP_MOV_IDX_A 8'hF6
`define OP_MOV_IDX_DIR 8'hA6
`define OP_MOV_IDX_IMM 8'h76
`define OP_LD_DP 8'h90
`define OP_CRD_DP 8'h93
`define OP_CRD_PC 8'h83
`define OP_XRD_IDX 8'hE2
`define OP_XRD_DP 8'hE0
`define OP_XWR_IDX 8'hF2
`define OP_XWR_DP 8'hF0
`define OP_PUSH 8'hC0
`define OP_POP 8'hD0
`define OP_XCH_WREG 8'hC8
`define OP_XCH_DIR 8'hC5
`define OP_XCH_IDX 8'hC6
`define OP_LNX 8'hD6
`define OP_SJMP 8'h80
`define OP_JMP_IND 8'h73
`define OP_JZ 8'h60
`define OP_JNZ 8'h70
`define OP_JC 8'h40
`define OP_JNC 8'h50
`define OP_JB 8'h20
`define OP_JNB 8'h30
`define OP_TCB 8'h10
`define OP_CBU_DIR 8'hB5
`define OP_CBU_IMM 8'hB4
`define OP_CBU_WREG 8'hB8
`define OP_CBU_IDX 8'hB6
`define OP_DBN_WREG 8'hD8
`define OP_DBN_DIR 8'hD5
`define OP_NOP 8'h00
`define OP_CLR_C 8'hC3
`define OP_SETB_C 8'hD3
`define OP_CPL_C 8'hB3
`define OP_CLR_BIT 8'hC2
`define OP_SETB_BIT 8'hD2
`define OP_CPL_BIT 8'hB2
`define OP_ANL_C 8'h82
`define OP_ANL_CN 8'hB0
`define OP_ORL_C 8'h72
`define OP_ORL_CN 8'hA0
`define OP_MOV_C_BIT 8'hA2
`define OP_MOV_BIT_C 8'h92
// Shapes: {byte length, cycle count}
`define SH_1B1C {2'h1, 3'h1}
`define SH_1B2C {2'h1, 3'h2}
`define SH_1B3C {2'h1, 3'h3}
`define SH_1B4C {2'h1, 3'h4}
`define SH_1B5C {2'h1, 3'h5}
`define SH_2B2C {2'h2, 3'h2}
`define SH_2B3C {2'h2, 3'h3}
`define SH_2B4C {2'h2, 3'h4}
`define SH_2B5C {2'h2, 3'h5}
`define SH_3B3C {2'h3, 3'h3}
`define SH_3B4C {2'h3, 3'h4}
`define LEN_MAX 2'h3
`define CYC_MIN 3'h1
`define CNT_BIAS 3'h2
`define CNT_LAST 3'h0
`define XRD_CNT 3'h2
`define XWR_CNT 3'h1
`define CRD_CNT 3'h1
`define PC_RST 16'h0000
`define SP_RST 8'h07
`define IDX_BASE 7'h00
`define WREG_BASE 5'h00
`define BIT_LO_BASE 4'h2
`define XIDX_HI 8'h00
`endif

// *** hdl/cmb_decode_core.sv ***
// Decoder and executor for the move, branch and bit instruction groups
// Notes on behaviour
// - 0x75: immediate to direct, 3 bytes, 3 cycles
// - Accumulator or immediate to indexed location, 3 cycles
// - Direct byte to indexed location, 5 cycles
// - 0x90 loads data pointer from two bytes
// - Code byte at A plus pointer or PC
// - External read to accumulator, four cycles
// - External write from accumulator, five cycles
// - Memory write select picks external access target
// - Push four cycles, pop three, two bytes
// - Accumulator exchange with register, direct, indirect
// - Low nibble exchange keeps both high nibbles
// - Short jump by signed second byte
// - Jump to accumulator plus data pointer
// - Branch on accumulator zero or nonzero
// - Branch on carry set or clear
// - Branch on direct bit set or clear
// - Branch on bit set, then clear it
// - Compare branch unequal forms, 3 bytes, 4 cycles
// - Decrement and branch if result nonzero
// - Clear, set, invert bit or carry
// - AND or OR bit, or inverse, into carry
// - Move bit to carry and carry to bit
`timescale 1ns/10ps
`include "cmb_consts.svh"

module cmb_decode_core import cmb_pkg::*; (
  input wire logic core_clk,
  input wire logic srst,
  input wire cmb_code_t codeData,
  input wire logic [7:0] xRdData,
  input wire logic memWrSel,
  output logic [15:0] codeAddr,
  output cmb_xreq_t xReq,
  output logic [7:0] accOut,
  output logic carryOut,
  output logic [15:0] dataPtrOut,
  output logic [15:0] pcOut,
  output logic [7:0] spOut,
  output logic insnDone,
  output logic badOpcode
);

  // ==========================================================
  // Decode table
  function automatic cmb_info_t mk(input cmb_cls_t c, input logic [4:0] s);
    mk = cmb_info_t'({c, s});
  endfunction

  function automatic cmb_info_t classify(input logic [7:0] op);
    logic [7:0] k;
    logic [7:0] wr;
    k = op;
    wr = {op[7:3], 3'h0};
    // Fold register and index register forms onto their lowest code
    if (wr == `OP_XCH_WREG || wr == `OP_CBU_WREG || wr == `OP_DBN_WREG) begin
      k = wr;
    end else if (op[3:1] == 3'h3 || (op[7:5] == 3'h7 && op[3:1] == 3'h1)) begin
      k = {op[7:1], 1'b0};
    end
    case (k)
      `OP_MOV_DIR_IMM: classify = mk(C_MOV_DIR_IMM, `SH_3B3C);
      `OP_MOV_IDX_A: classify = mk(C_MOV_IDX_A, `SH_1B3C);
      `OP_MOV_IDX_IMM: classify = mk(C_MOV_IDX_IMM, `SH_2B3C);
      `OP_MOV_IDX_DIR: classify = mk(C_MOV_IDX_DIR, `SH_2B5C);
      `OP_LD_DP: classify = mk(C_LD_DP, `SH_3B3C);
      `OP_CRD_DP: classify = mk(C_CRD_DP, `SH_1B3C);
      `OP_CRD_PC: classify = mk(C_CRD_PC, `SH_1B3C);
      `OP_XRD_IDX: classify = mk(C_XRD_IDX, `SH_1B4C);
      `OP_XRD_DP: classify = mk(C_XRD_DP, `SH_1B4C);
      `OP_XWR_IDX: classify = mk(C_XWR_IDX, `SH_1B5C);
      `OP_XWR_DP: classify = mk(C_XWR_DP, `SH_1B5C);
      `OP_PUSH: classify = mk(C_PUSH, `SH_2B4C);
      `OP_POP: classify = mk(C_POP, `SH_2B3C);
      `OP_XCH_WREG: classify = mk(C_XCH_WREG, `SH_1B2C);
      `OP_XCH_DIR: classify = mk(C_XCH_DIR, `SH_2B3C);
      `OP_XCH_IDX: classify = mk(C_XCH_IDX, `SH_1B3C);
      `OP_LNX: classify = mk(C_LNX, `SH_1B3C);
      `OP_SJMP: classify = mk(C_SJMP, `SH_2B3C);
      `OP_JMP_IND: classify = mk(C_JMP_IND, `SH_1B2C);
      `OP_JZ: classify = mk(C_JZ, `SH_2B3C);
      `OP_JNZ: classify = mk(C_JNZ, `SH_2B3C);
      `OP_JC: classify = mk(C_JC, `SH_2B3C);
      `OP_JNC: classify = mk(C_JNC, `SH_2B3C);
      `OP_JB: classify = mk(C_JB, `SH_3B4C);
      `OP_JNB: classify = mk(C_JNB, `SH_3B4C);
      `OP_TCB: classify = mk(C_TCB, `SH_3B4C);
      `OP_CBU_DIR: classify = mk(C_CBU_DIR, `SH_3B4C);
      `OP_CBU_IMM: classify = mk(C_CBU_IMM, `SH_3B4C);
      `OP_CBU_WREG: classify = mk(C_CBU_WREG, `SH_3B4C);
      `OP_CBU_IDX: classify = mk(C_CBU_IDX, `SH_3B4C);
      `OP_DBN_WREG: classify = mk(C_DBN_WREG, `SH_2B3C);
      `OP_DBN_DIR: classify = mk(C_DBN_DIR, `SH_3B4C);
      `OP_NOP: classify = mk(C_NOP, `SH_1B1C);
      `OP_CLR_C: classify = mk(C_CLR_C, `SH_1B1C);
      `OP_SETB_C: classify = mk(C_SETB_C, `SH_1B1C);
      `OP_CPL_C: classify = mk(C_CPL_C, `SH_1B1C);
      `OP_CLR_BIT: classify = mk(C_CLR_BIT, `SH_2B3C);
      `OP_SETB_BIT: classify = mk(C_SETB_BIT, `SH_2B3C);
      `OP_CPL_BIT: classify = mk(C_CPL_BIT, `SH_2B3C);
      `OP_ANL_C: classify = mk(C_ANL_C, `SH_2B2C);
      `OP_ANL_CN: classify = mk(C_ANL_CN, `SH_2B2C);
      `OP_ORL_C: classify = mk(C_ORL_C, `SH_2B2C);
      `OP_ORL_CN: classify = mk(C_ORL_CN, `SH_2B2C);
      `OP_MOV_C_BIT: classify = mk(C_MOV_C_BIT, `SH_2B2C);
      `OP_MOV_BIT_C: classify = mk(C_MOV_BIT_C, `SH_2B3C);
      // Codes of other groups are skipped as one-byte, one-cycle
      default: classify = mk(C_BAD, `SH_1B1C);
    endcase
  endfunction

  // ==========================================================
  // State and operand fetch
  cmb_state_t st_r;
  cmb_info_t info_r;
  cmb_info_t cur;
  cmb_code_t ir_r;
  cmb_code_t ins;
  cmb_xreq_t xReq_r;
  logic [2:0] cnt_r;
  // Upper half doubles as the direct special area; no separate registers
  logic [7:0] iram [0:255];
  logic [7:0] acc_r;
  logic [7:0] sp_r;
  logic cy_r;
  logic [15:0] dp_r;
  logic [15:0] pc_r;
  logic [15:0] codeAddr_r;
  logic done_r;
  logic bad_r;
  logic fin;
  logic [7:0] op;
  logic [7:0] b1;
  logic [7:0] b2;
  logic [7:0] riA;
  logic [7:0] riV;
  logic [7:0] wrA;
  logic [7:0] wrV;
  logic [7:0] dirV;
  logic [7:0] bitA;
  logic [7:0] bitV8;
  logic [7:0] bitMask;
  logic [7:0] rel;
  logic bitV;
  logic [15:0] seqPc;
  logic [15:0] relPc;

  assign ins = (st_r == ST_DEC) ? codeData : ir_r;
  assign cur = (st_r == ST_DEC) ? classify(codeData.b0) : info_r;
  // One-cycle forms finish in the decode cycle itself
  assign fin = (st_r == ST_DEC) ? (cur.cyc == `CYC_MIN) : (cnt_r == `CNT_LAST);
  assign op = ins.b0;
  assign b1 = ins.b1;
  assign b2 = ins.b2;
  // Working and index registers live in bank zero only
  assign riA = iram[{`IDX_BASE, op[0]}];
  assign riV = iram[riA];
  assign wrA = {`WREG_BASE, op[2:0]};
  assign wrV = iram[wrA];
  assign dirV = iram[b1];
  assign bitA = b1[7] ? {b1[7:3], 3'h0} : {`BIT_LO_BASE, b1[6:3]};
  assign bitV8 = iram[bitA];
  assign bitMask = 8'h01 << b1[2:0];
  assign bitV = bitV8[b1[2:0]];
  assign seqPc = pc_r + {14'h0000, cur.len};
  assign rel = (cur.len == `LEN_MAX) ? b2 : b1;
  assign relPc = seqPc + {{8{rel[7]}}, rel};

  // ==========================================================
  // Execution
  logic [7:0] accNxt;
  logic [7:0] spNxt;
  logic [7:0] wAddr;
  logic [7:0] wData;
  logic [7:0] cmpA;
  logic [7:0] cmpB;
  logic [7:0] decV;
  logic [15:0] dpNxt;
  logic [15:0] pcNxt;
  logic cyNxt;
  logic wEn;
  logic take;
  logic bitW;
  logic bitDin;

  always_comb begin
    accNxt = acc_r;
    cyNxt = cy_r;
    dpNxt = dp_r;
    spNxt = sp_r;
    pcNxt = seqPc;
    wEn = 1'b0;
    wAddr = b1;
    wData = acc_r;
    take = 1'b0;
    bitW = 1'b0;
    bitDin = 1'b0;
    cmpA = acc_r;
    cmpB = b1;
    decV = dirV - 8'h01;
    case (cur.cls)
      C_MOV_DIR_IMM: begin
        wEn = 1'b1;
        wData = b2;
      end
      C_MOV_IDX_A: begin
        wEn = 1'b1;
        wAddr = riA;
      end
      C_MOV_IDX_IMM: begin
        wEn = 1'b1;
        wAddr = riA;
        wData = b1;
      end
      C_MOV_IDX_DIR: begin
        wEn = 1'b1;
        wAddr = riA;
        wData = dirV;
      end
      C_LD_DP: dpNxt = {b1, b2};
      C_CRD_DP, C_CRD_PC: accNxt = codeData.b0;
      C_XRD_IDX, C_XRD_DP: accNxt = xRdData;
      C_PUSH: begin
        spNxt = sp_r + 8'h01;
        wEn = 1'b1;
        wAddr = spNxt;
        wData = dirV;
      end
      C_POP: begin
        spNxt = sp_r - 8'h01;
        wEn = 1'b1;
        wData = iram[sp_r];
      end
      C_XCH_WREG: begin
        accNxt = wrV;
        wEn = 1'b1;
        wAddr = wrA;
      end
      C_XCH_DIR: begin
        accNxt = dirV;
        wEn = 1'b1;
      end
      C_XCH_IDX: begin
        accNxt = riV;
        wEn = 1'b1;
        wAddr = riA;
      end
      C_LNX: begin
        accNxt = {acc_r[7:4], riV[3:0]};
        wEn = 1'b1;
        wAddr = riA;
        wData = {riV[7:4], acc_r[3:0]};
      end
      C_SJMP: take = 1'b1;
      C_JMP_IND: pcNxt = dp_r + {8'h00, acc_r};
      C_JZ: take = (acc_r == 8'h00);
      C_JNZ: take = (acc_r != 8'h00);
      C_JC: take = cy_r;
      C_JNC: take = !cy_r;
      C_JB: take = bitV;
      C_JNB: take = !bitV;
      C_TCB: begin
        take = bitV;
        bitW = bitV;
      end
      C_CBU_DIR, C_CBU_IMM, C_CBU_WREG, C_CBU_IDX: begin
        // Carry reports first operand below second, as the family does
        if (cur.cls == C_CBU_DIR) begin
          cmpB = dirV;
        end else if (cur.cls == C_CBU_WREG) begin
          cmpA = wrV;
        end else if (cur.cls == C_CBU_IDX) begin
          cmpA = riV;
        end
        take = (cmpA != cmpB);
        cyNxt = (cmpA < cmpB);
      end
      C_DBN_WREG, C_DBN_DIR: begin
        if (cur.cls == C_DBN_WREG) begin
          decV = wrV - 8'h01;
          wAddr = wrA;
        end
        wEn = 1'b1;
        wData = decV;
        take = (decV != 8'h00);
      end
      C_CLR_C: cyNxt = 1'b0;
      C_SETB_C: cyNxt = 1'b1;
      C_CPL_C: cyNxt = !cy_r;
      C_CLR_BIT: bitW = 1'b1;
      C_SETB_BIT: begin
        bitW = 1'b1;
        bitDin = 1'b1;
      end
      C_CPL_BIT: begin
        bitW = 1'b1;
        bitDin = !bitV;
      end
      C_ANL_C: cyNxt = cy_r & bitV;
      C_ANL_CN: cyNxt = cy_r & !bitV;
      C_ORL_C: cyNxt = cy_r | bitV;
      C_ORL_CN: cyNxt = cy_r | !bitV;
      C_MOV_C_BIT: cyNxt = bitV;
      C_MOV_BIT_C: begin
        bitW = 1'b1;
        bitDin = cy_r;
      end
      default: ;
    endcase
    // Bit writes are read-modify-write of the containing byte
    if (bitW) begin
      wEn = 1'b1;
      wAddr = bitA;
      wData = (bitV8 & ~bitMask) | ({8{bitDin}} & bitMask);
    end
    if (take) begin
      pcNxt = relPc;
    end
  end

  // ==========================================================
  // Sequencer
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_r <= ST_DEC;
      cnt_r <= `CNT_LAST;
      info_r <= '0;
      ir_r <= '0;
    end else begin
      case (st_r)
        ST_DEC: begin
          ir_r <= codeData;
          info_r <= cur;
          cnt_r <= cur.cyc - `CNT_BIAS;
          if (!fin) begin
            st_r <= ST_EXE;
          end
        end
        ST_EXE: begin
          cnt_r <= cnt_r - 3'h1;
          if (fin) begin
            st_r <= ST_DEC;
          end
        end
        default: st_r <= ST_DEC;
      endcase
    end
  end

  // ==========================================================
  // Architectural state
  always_ff @(posedge core_clk) begin
    if (srst) begin
      acc_r <= 8'h00;
      cy_r <= 1'b0;
      dp_r <= 16'h0000;
      sp_r <= `SP_RST;
      pc_r <= `PC_RST;
    end else if (fin) begin
      acc_r <= accNxt;
      cy_r <= cyNxt;
      dp_r <= dpNxt;
      sp_r <= spNxt;
      pc_r <= pcNxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (fin && wEn) begin
      iram[wAddr] <= wData;
    end
  end

  // ==========================================================
  // Program memory address
  always_ff @(posedge core_clk) begin
    if (srst) begin
      codeAddr_r <= `PC_RST;
    end else if (fin) begin
      codeAddr_r <= pcNxt;
    end else if (st_r == ST_EXE && cnt_r == `CRD_CNT) begin
      // Code read base is the pointer or the following instruction
      if (info_r.cls == C_CRD_DP) begin
        codeAddr_r <= dp_r + {8'h00, acc_r};
      end else if (info_r.cls == C_CRD_PC) begin
        codeAddr_r <= seqPc + {8'h00, acc_r};
      end
    end
  end

  // ==========================================================
  // External data strobes
  logic xIdx;
  logic xRd;
  logic xWr;

  assign xIdx = (info_r.cls == C_XRD_IDX) || (info_r.cls == C_XWR_IDX);
  assign xRd = (info_r.cls == C_XRD_IDX) || (info_r.cls == C_XRD_DP);
  assign xWr = (info_r.cls == C_XWR_IDX) || (info_r.cls == C_XWR_DP);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      xReq_r <= '0;
    end else begin
      xReq_r.rd <= 1'b0;
      xReq_r.wr <= 1'b0;
      if (st_r == ST_EXE && ((xRd && cnt_r == `XRD_CNT) || (xWr && cnt_r == `XWR_CNT))) begin
        xReq_r.rd <= xRd;
        xReq_r.wr <= xWr;
        xReq_r.addr <= xIdx ? {`XIDX_HI, riA} : dp_r;
        xReq_r.wdata <= acc_r;
        xReq_r.codeSpace <= memWrSel;
      end
    end
  end

  // ==========================================================
  // Status pulses
  always_ff @(posedge core_clk) begin
    if (srst) begin
      done_r <= 1'b0;
      bad_r <= 1'b0;
    end else begin
      done_r <= fin;
      bad_r <= fin && (cur.cls == C_BAD);
    end
  end

  assign codeAddr = codeAddr_r;
  assign xReq = xReq_r;
  assign accOut = acc_r;
  assign carryOut = cy_r;
  assign dataPtrOut = dp_r;
  assign pcOut = pc_r;
  assign spOut = sp_r;
  assign insnDone = done_r;
  assign badOpcode = bad_r;

endmodule

// *** hdl/cmb_pkg.sv ***
// Types shared by the move, branch and bit instruction decoder
package cmb_pkg;
  typedef enum logic [5:0] {
    C_BAD, C_MOV_DIR_IMM, C_MOV_IDX_A, C_MOV_IDX_DIR, C_MOV_IDX_IMM, C_LD_DP,
    C_CRD_DP, C_CRD_PC, C_XRD_IDX, C_XRD_DP, C_XWR_IDX, C_XWR_DP, C_PUSH, C_POP,
    C_XCH_WREG, C_XCH_DIR, C_XCH_IDX, C_LNX, C_SJMP, C_JMP_IND, C_JZ, C_JNZ,
    C_JC, C_JNC, C_JB, C_JNB, C_TCB, C_CBU_DIR, C_CBU_IMM, C_CBU_WREG, C_CBU_IDX,
    C_DBN_WREG, C_DBN_DIR, C_NOP, C_CLR_C, C_SETB_C, C_CPL_C, C_CLR_BIT,
    C_SETB_BIT, C_CPL_BIT, C_ANL_C, C_ANL_CN, C_ORL_C, C_ORL_CN, C_MOV_C_BIT,
    C_MOV_BIT_C
  } cmb_cls_t;
  typedef enum {ST_DEC, ST_EXE} cmb_state_t;
  typedef struct packed {
    cmb_cls_t cls;
    logic [1:0] len;
    logic [2:0] cyc;
  } cmb_info_t;
  typedef struct packed {
    logic [7:0] b2;
    logic [7:0] b1;
    logic [7:0] b0;
  } cmb_code_t;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic rd;
    logic wr;
    logic codeSpace;
  } cmb_xreq_t;
endpackage
